// ==== pkg/idc_pkg.sv ====
// Shared constants and types for the injector and solenoid driver control
`default_nettype none

package idc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and tick timing
    localparam int CLK_NS = 10;
    localparam int TICK_NS = 500;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam logic [5:0] TICK_LAST = 6'(TICK_CYC - 1);
    // Early rise-rate window at the start of each injection event
    localparam int EARLY_NS = 100000;
    localparam int EARLY_TICKS = EARLY_NS / TICK_NS;
    localparam logic [7:0] EARLY_INIT = 8'(EARLY_TICKS);
    // Parameter refresh interval and staleness limit (two intervals)
    localparam int REFRESH_NS = 200000;
    localparam int STALE_CYC_DEF = (2 * REFRESH_NS) / CLK_NS;

    ////////////////////////////////////////////////////////////////////////
    // Channel counts and widths
    localparam int N_INJ = 4;
    localparam int N_SOL = 4;
    localparam int PWM_W = 20;
    localparam int PEAK_W = 16;

    ////////////////////////////////////////////////////////////////////////
    // Serial frame layout, bit 0 is the last bit shifted in
    localparam int SOL_ON_POS = 0;
    localparam int SOL_PER_POS = 20;
    localparam int SOL_EN_POS = 40;
    localparam int SOL_FIELD = 41;
    localparam int INJ_BASE = 164;
    localparam int CLR_BASE = 228;
    localparam int CLR_INJ_OPEN = 0;
    localparam int CLR_INJ_SHORT = 4;
    localparam int CLR_SOL_OPEN = 8;
    localparam int CLR_SOL_SHORT = 12;
    localparam int CLR_W = 16;
    localparam int FRAME_BITS = 244;
    localparam logic [7:0] FRAME_LEN = 8'(FRAME_BITS);

    ////////////////////////////////////////////////////////////////////////
    // Synchronised input bit positions
    localparam int SYNC_W = 32;
    localparam int SY_SCLK = 0;
    localparam int SY_SDAT = 1;
    localparam int SY_SFRM = 2;
    localparam int SY_SUP = 3;
    localparam int SY_CMD = 4;
    localparam int SY_PEAK = 8;
    localparam int SY_HOLD = 12;
    localparam int SY_RISE = 16;
    localparam int SY_OVER = 20;
    localparam int SY_SOPEN = 24;
    localparam int SY_SSHORT = 28;

    // Injector channel phases
    typedef enum logic [1:0] {
        INJ_IDLE = 2'h0,
        INJ_PEAK = 2'h1,
        INJ_HOLD = 2'h2
    } idc_inj_state_t;

endpackage : idc_pkg

`default_nettype wire

// ==== verilog/idc_inj_chan.sv ====
// One peak/hold injector channel with open and short supervision
`timescale 1ns/100ps
`default_nettype none

module idc_inj_chan (
    // Clock, reset and freeze
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic tick,
    // Command, peak time and flag clears
    input wire logic cmd,
    input wire logic [15:0] peak_ticks,
    input wire logic clr_open,
    input wire logic clr_short,
    // Current comparators
    input wire logic peak_hit,
    input wire logic hold_hit,
    input wire logic rise_fast,
    input wire logic over_cur,
    // Drive and status
    output logic drive,
    output logic peak_sel,
    output logic open_flag,
    output logic short_flag
);

    idc_pkg::idc_inj_state_t state, next_state;
    logic [15:0] cnt, next_cnt;
    logic [7:0] early, next_early;
    logic reached, next_reached, next_open, next_short;
    logic short_set, open_set;

    // Phase decode straight from the state flops
    assign drive = (state != idc_pkg::INJ_IDLE);
    assign peak_sel = (state == idc_pkg::INJ_PEAK);

    ////////////////////////////////////////////////////////////////////////
    // Event sequencing and fault flags
    always_comb
    begin
        short_set = drive && ((early != 8'h00 && rise_fast) || (early == 8'h00 && over_cur));
        open_set = drive && !cmd && !(reached || peak_hit || hold_hit);
        next_state = state;
        next_cnt = cnt;
        next_early = early;
        next_reached = reached | peak_hit | hold_hit;
        case (state)
            idc_pkg::INJ_IDLE:
            begin
                next_reached = 1'b0;
                if (cmd && !short_flag)
                begin
                    next_cnt = peak_ticks;
                    next_early = idc_pkg::EARLY_INIT;
                    // Zero peak time runs the whole event at hold level
                    next_state = (peak_ticks == 16'h0000) ? idc_pkg::INJ_HOLD : idc_pkg::INJ_PEAK;
                end
            end
            idc_pkg::INJ_PEAK:
            begin
                if (tick)
                begin
                    next_cnt = cnt - 16'h0001;
                    if (cnt == 16'h0001)
                        next_state = idc_pkg::INJ_HOLD;
                end
            end
            idc_pkg::INJ_HOLD:
                next_state = idc_pkg::INJ_HOLD;
            default:
                next_state = idc_pkg::INJ_IDLE;
        endcase
        if (drive && tick && early != 8'h00)
            next_early = early - 8'h01;
        // Event ends with the command or on a short
        if (drive && (!cmd || short_set))
            next_state = idc_pkg::INJ_IDLE;
        // Set wins over clear on both flags
        next_open = open_set || (open_flag && !clr_open);
        next_short = short_set || (short_flag && !(clr_short && !cmd));
    end

    // State registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= idc_pkg::INJ_IDLE;
            cnt <= '0;
            early <= '0;
            reached <= 1'b0;
            open_flag <= 1'b0;
            short_flag <= 1'b0;
        end
        else if (ce)
        begin
            state <= next_state;
            cnt <= next_cnt;
            early <= next_early;
            reached <= next_reached;
            open_flag <= next_open;
            short_flag <= next_short;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    short_off_a: assert property (@(posedge clk) disable iff (reset || !ce)
        short_flag |-> !drive) else $error("injector driven while short flagged");
    short_keep_a: assert property (@(posedge clk) disable iff (reset || !ce)
        short_flag && cmd |=> short_flag) else $error("short flag cleared under command");
    late_short_a: assert property (@(posedge clk) disable iff (reset || !ce)
        drive && early == 8'h00 && over_cur |=> short_flag && !drive)
        else $error("late short not caught");
    peak_end_a: assert property (@(posedge clk) disable iff (reset || !ce)
        peak_sel && tick && cnt == 16'h0001 && cmd && !short_set |=> state == idc_pkg::INJ_HOLD)
        else $error("peak did not fold back to hold");
    open_set_a: assert property (@(posedge clk) disable iff (reset || !ce)
        open_set |=> open_flag) else $error("open circuit not reported");
    hold_direct_a: assert property (@(posedge clk) disable iff (reset || !ce)
        !drive && cmd && !short_flag && peak_ticks == 16'h0000 |=> state == idc_pkg::INJ_HOLD)
        else $error("zero peak did not start in hold");
    hold_entry_c: cover property (@(posedge clk) disable iff (reset || !ce)
        peak_sel ##1 state == idc_pkg::INJ_HOLD);

endmodule : idc_inj_chan

`default_nettype wire

// ==== verilog/idc_pwm_chan.sv ====
// One low-side solenoid PWM channel with open and short supervision
`timescale 1ns/100ps
`default_nettype none

module idc_pwm_chan (
    // Clock, reset and freeze
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic tick,
    // Parameters and flag clears
    input wire logic en,
    input wire logic [19:0] period,
    input wire logic [19:0] on_time,
    input wire logic clr_open,
    input wire logic clr_short,
    // Load sensing
    input wire logic open_sense,
    input wire logic short_sense,
    // Drive and status
    output logic drive,
    output logic open_flag,
    output logic short_flag
);

    logic [19:0] cnt, next_cnt, per_a, next_per, on_a, next_on;
    logic next_drive, next_open, next_short;
    logic bound, cmd, short_set, open_set;

    ////////////////////////////////////////////////////////////////////////
    // Period counter, duty compare and fault flags
    always_comb
    begin
        bound = (per_a == 20'h00000) || (cnt >= per_a - 20'h00001);
        // Zero on-time never drives, on-time at or past period always drives
        cmd = en && (cnt < on_a);
        next_cnt = cnt;
        next_per = per_a;
        next_on = on_a;
        if (!en)
        begin
            next_cnt = '0;
            next_per = period;
            next_on = on_time;
        end
        else if (tick)
        begin
            if (bound)
            begin
                // While enabled, new values only at the boundary: no runt pulses
                next_cnt = '0;
                next_per = period;
                next_on = on_time;
            end
            else
                next_cnt = cnt + 20'h00001;
        end
        short_set = drive && short_sense;
        open_set = !drive && open_sense;
        // Open flag plays no part in the drive path
        next_drive = cmd && !short_flag && !short_set;
        next_open = open_set || (open_flag && !clr_open);
        next_short = short_set || (short_flag && !(clr_short && !cmd));
    end

    // State registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cnt <= '0;
            per_a <= '0;
            on_a <= '0;
            drive <= 1'b0;
            open_flag <= 1'b0;
            short_flag <= 1'b0;
        end
        else if (ce)
        begin
            cnt <= next_cnt;
            per_a <= next_per;
            on_a <= next_on;
            drive <= next_drive;
            open_flag <= next_open;
            short_flag <= next_short;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    short_block_a: assert property (@(posedge clk) disable iff (reset || !ce)
        short_flag |-> !drive) else $error("solenoid driven while short flagged");
    short_keep_a: assert property (@(posedge clk) disable iff (reset || !ce)
        short_flag && cmd |=> short_flag) else $error("short flag cleared while on");
    cnt_range_a: assert property (@(posedge clk) disable iff (reset || !ce)
        per_a != 20'h00000 |-> cnt < per_a) else $error("period counter overran");
    reload_a: assert property (@(posedge clk) disable iff (reset || !ce)
        en && tick && bound |=> on_a == $past(on_time) && cnt == 20'h00000)
        else $error("boundary reload missed");
    open_set_a: assert property (@(posedge clk) disable iff (reset || !ce)
        !drive && open_sense |=> open_flag) else $error("open load not flagged");
    short_set_c: cover property (@(posedge clk) disable iff (reset || !ce)
        drive && short_sense ##1 short_flag);

endmodule : idc_pwm_chan

`default_nettype wire

// ==== verilog/idc_top.sv ====
// Injector and solenoid driver control: input sync, parameter link, channels
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Function
// - Injector runs peak level for requested peak time, then hold level.
// - Injector peak time refreshed from host every fixed interval.
// - Flag open circuit if no threshold reached during whole event.
// - Early fast current rise sets short flag and disables channel.
// - Short check continues later in event with same flag and disable.
// - Injector short clear ignored while event commanded.
// - No mode setting; hold regulation applies once hold threshold reached.
// - Independent PWM per solenoid, zero is off, full scale always on.
// - Enable, period, on-time sent serially from host at fixed interval.
// - PWM counts period and on-time with 20-bit counter at 2 MHz.
// - Open load tested while off; sticky flag, software clearable.
// - Solenoid open flag never changes drive behaviour.
// - Short while on sets flag; channel disabled until cleared.
// - Solenoid short clear ignored while switch commanded on.
// - No injection without engine angle supervision.

module idc_top #(
    parameter int STALE_CYC = idc_pkg::STALE_CYC_DEF
) (
    // Clock, reset and freeze
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Serial parameter link from host logic
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_frame,
    // Engine angle supervision and injection commands
    input wire logic engine_angle_supervisor_input,
    input wire logic [3:0] injection_command_bundle,
    // Injector current comparators
    input wire logic [3:0] inj_peak_hit,
    input wire logic [3:0] inj_hold_hit,
    input wire logic [3:0] inj_rise_fast,
    input wire logic [3:0] inj_over_cur,
    // Solenoid load sensing
    input wire logic [3:0] sol_open_sense,
    input wire logic [3:0] sol_short_sense,
    // Injector drive and status
    output logic [3:0] inj_drive,
    output logic [3:0] inj_peak_sel,
    output logic [3:0] inj_open_flag,
    output logic [3:0] inj_short_flag,
    // Solenoid drive and status
    output logic [3:0] sol_drive,
    output logic [3:0] sol_open_flag,
    output logic [3:0] sol_short_flag,
    // Link status
    output logic frame_ok,
    output logic frame_err,
    output logic params_stale
);

    localparam logic [23:0] STALE_LIM = 24'(STALE_CYC);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [idc_pkg::SYNC_W-1:0] raw_in, s1, s2, s3, filt, next_filt;
    logic sclk, sdat, sfrm, sup;
    logic [3:0] cmd_s, peak_s, hold_s, rise_s, over_s, sopen_s, sshort_s;

    assign raw_in = {sol_short_sense, sol_open_sense, inj_over_cur, inj_rise_fast,
                     inj_hold_hit, inj_peak_hit, injection_command_bundle,
                     engine_angle_supervisor_input, ser_frame, ser_data, ser_clk};

    // A change is accepted only once the second and third stages agree
    always_comb
    begin
        next_filt = (s2 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
    end

    // Three-stage chain; the first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            filt <= '0;
        end
        else if (ce)
        begin
            s1 <= raw_in;
            s2 <= s1;
            s3 <= s2;
            filt <= next_filt;
        end
    end

    // Named views of the filtered inputs
    assign sclk = filt[idc_pkg::SY_SCLK];
    assign sdat = filt[idc_pkg::SY_SDAT];
    assign sfrm = filt[idc_pkg::SY_SFRM];
    assign sup = filt[idc_pkg::SY_SUP];
    assign cmd_s = filt[idc_pkg::SY_CMD +: 4];
    assign peak_s = filt[idc_pkg::SY_PEAK +: 4];
    assign hold_s = filt[idc_pkg::SY_HOLD +: 4];
    assign rise_s = filt[idc_pkg::SY_RISE +: 4];
    assign over_s = filt[idc_pkg::SY_OVER +: 4];
    assign sopen_s = filt[idc_pkg::SY_SOPEN +: 4];
    assign sshort_s = filt[idc_pkg::SY_SSHORT +: 4];

    ////////////////////////////////////////////////////////////////////////
    // Serial frame receiver
    logic sclk_d, sfrm_d;
    logic [idc_pkg::FRAME_BITS-1:0] shreg, next_shreg, frame_q, next_frame_q;
    logic [7:0] bitcnt, next_bitcnt;
    logic [idc_pkg::CLR_W-1:0] clr_q, next_clr;
    logic next_ok, next_err;

    // Shift on each link clock rise inside the frame, commit on frame end
    always_comb
    begin
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_frame_q = frame_q;
        next_clr = '0;
        next_ok = 1'b0;
        next_err = 1'b0;
        if (sfrm && !sfrm_d)
            next_bitcnt = '0;
        else if (sfrm && sclk && !sclk_d)
        begin
            next_shreg = {shreg[idc_pkg::FRAME_BITS-2:0], sdat};
            if (bitcnt != 8'hFF)
                next_bitcnt = bitcnt + 8'h01;
        end
        else if (!sfrm && sfrm_d)
        begin
            // A short or long frame is dropped whole, old values stay
            if (bitcnt == idc_pkg::FRAME_LEN)
            begin
                next_frame_q = shreg;
                next_clr = shreg[idc_pkg::CLR_BASE +: idc_pkg::CLR_W];
                next_ok = 1'b1;
            end
            else
                next_err = 1'b1;
        end
    end

    // Receiver registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sclk_d <= 1'b0;
            sfrm_d <= 1'b0;
            shreg <= '0;
            bitcnt <= '0;
            frame_q <= '0;
            clr_q <= '0;
            frame_ok <= 1'b0;
            frame_err <= 1'b0;
        end
        else if (ce)
        begin
            sclk_d <= sclk;
            sfrm_d <= sfrm;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            frame_q <= next_frame_q;
            clr_q <= next_clr;
            frame_ok <= next_ok;
            frame_err <= next_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Refresh watchdog: status only, channels keep the last good values
    logic [23:0] stale_cnt, next_stale_cnt;
    logic next_stale;

    always_comb
    begin
        next_stale_cnt = stale_cnt;
        if (next_ok)
            next_stale_cnt = '0;
        else if (stale_cnt != STALE_LIM)
            next_stale_cnt = stale_cnt + 24'h000001;
        next_stale = (next_stale_cnt == STALE_LIM);
    end

    // Watchdog registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            stale_cnt <= '0;
            params_stale <= 1'b0;
        end
        else if (ce)
        begin
            stale_cnt <= next_stale_cnt;
            params_stale <= next_stale;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // 2 MHz tick shared by all channels
    logic [5:0] pre, next_pre;
    logic tick, next_tick;

    always_comb
    begin
        next_tick = (pre == idc_pkg::TICK_LAST);
        next_pre = next_tick ? 6'h00 : pre + 6'h01;
    end

    // Prescaler registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pre <= '0;
            tick <= 1'b0;
        end
        else if (ce)
        begin
            pre <= next_pre;
            tick <= next_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channels
    for (genvar i = 0; i < idc_pkg::N_INJ; i++)
    begin : g_chan
        // Injection only passes with supervision present
        idc_inj_chan u_inj (
            .clk(clk),
            .reset(reset),
            .ce(ce),
            .tick(tick),
            .cmd(cmd_s[i] & sup),
            .peak_ticks(frame_q[idc_pkg::INJ_BASE + i * idc_pkg::PEAK_W +: idc_pkg::PEAK_W]),
            .clr_open(clr_q[idc_pkg::CLR_INJ_OPEN + i]),
            .clr_short(clr_q[idc_pkg::CLR_INJ_SHORT + i]),
            .peak_hit(peak_s[i]),
            .hold_hit(hold_s[i]),
            .rise_fast(rise_s[i]),
            .over_cur(over_s[i]),
            .drive(inj_drive[i]),
            .peak_sel(inj_peak_sel[i]),
            .open_flag(inj_open_flag[i]),
            .short_flag(inj_short_flag[i])
        );

        // Solenoid PWM from its own frame field
        idc_pwm_chan u_pwm (
            .clk(clk),
            .reset(reset),
            .ce(ce),
            .tick(tick),
            .en(frame_q[i * idc_pkg::SOL_FIELD + idc_pkg::SOL_EN_POS]),
            .period(frame_q[i * idc_pkg::SOL_FIELD + idc_pkg::SOL_PER_POS +: idc_pkg::PWM_W]),
            .on_time(frame_q[i * idc_pkg::SOL_FIELD + idc_pkg::SOL_ON_POS +: idc_pkg::PWM_W]),
            .clr_open(clr_q[idc_pkg::CLR_SOL_OPEN + i]),
            .clr_short(clr_q[idc_pkg::CLR_SOL_SHORT + i]),
            .open_sense(sopen_s[i]),
            .short_sense(sshort_s[i]),
            .drive(sol_drive[i]),
            .open_flag(sol_open_flag[i]),
            .short_flag(sol_short_flag[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    tick_spacing_a: assert property (@(posedge clk) disable iff (reset || !ce)
        tick |=> (!tick)[*8] ##42 tick) else $error("tick not every 50 cycles");
    frame_load_a: assert property (@(posedge clk) disable iff (reset || !ce)
        frame_ok |-> frame_q == $past(shreg)) else $error("frame not committed");
    refresh_a: assert property (@(posedge clk) disable iff (reset || !ce)
        frame_ok |=> !params_stale) else $error("stale after fresh frame");
    supervise_a: assert property (@(posedge clk) disable iff (reset || !ce)
        !sup |=> inj_drive == 4'h0) else $error("injection without supervision");
    frame_ok_c: cover property (@(posedge clk) disable iff (reset || !ce) frame_ok);
    frame_err_c: cover property (@(posedge clk) disable iff (reset || !ce) frame_err);
    // A refused frame leaves every parameter as it was
    bad_frame_a: assert property (@(posedge clk) disable iff (reset || !ce)
        frame_err |-> $stable(frame_q)) else $error("refused frame changed parameters");
    // Clear pulses only ever ride on a commit
    clr_pulse_a: assert property (@(posedge clk) disable iff (reset || !ce)
        clr_q != '0 |-> frame_ok) else $error("clear pulse outside commit");
    stale_c: cover property (@(posedge clk) disable iff (reset || !ce) params_stale);

endmodule : idc_top

`default_nettype wire

// ==== tb/idc_host_model.sv ====
// Host link model: serial parameter frames
`timescale 1ns/100ps
`default_nettype none

module idc_host_model (
    // Link pins
    input wire logic clk,
    output logic ser_clk,
    output logic ser_data,
    output logic ser_frame
);
    // Link clock stands still between frames
    initial {ser_clk, ser_data, ser_frame} = 3'h0;

    // Five cycles a level: two whole cycles of the 40 MHz host clock
    task automatic send(input logic [243:0] f, input int nb);
        ser_frame = 1'b1;
        // Fewer than 244 bits makes a cut frame
        for (int i = 243; i > 243 - nb; i--)
        begin
            ser_data = f[i];
            repeat (5) @(negedge clk);
            ser_clk = 1'b1;
            repeat (5) @(negedge clk);
            ser_clk = 1'b0;
        end
        // Released data shows the inverse of the last bit
        ser_data = ~f[244 - nb];
        repeat (5) @(negedge clk);
        ser_frame = 1'b0;
    endtask : send
endmodule : idc_host_model

`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the injector and solenoid control
`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic clk, reset, ce, sup, sclk, sdat, sfrm, fok, ferr, stale;
    logic [3:0] cmd, pk, hd, rf, oc, so, ss, idr, ips, iof, isf, sdr, sof, ssf;
    logic [243:0] f;
    logic [7:0] lf;
    int mismatches, checks, n, ena[4], per[4], ont[4];
    localparam int TC = idc_pkg::TICK_CYC;

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    idc_host_model u_host (.clk(clk), .ser_clk(sclk), .ser_data(sdat), .ser_frame(sfrm));

    // Short stale limit keeps the run brief
    idc_top #(.STALE_CYC(200)) u_dut (
        .clk(clk), .reset(reset), .ce(ce), .ser_clk(sclk), .ser_data(sdat), .ser_frame(sfrm),
        .engine_angle_supervisor_input(sup), .injection_command_bundle(cmd),
        .inj_peak_hit(pk), .inj_hold_hit(hd), .inj_rise_fast(rf), .inj_over_cur(oc),
        .sol_open_sense(so), .sol_short_sense(ss), .inj_drive(idr), .inj_peak_sel(ips),
        .inj_open_flag(iof), .inj_short_flag(isf), .sol_drive(sdr), .sol_open_flag(sof),
        .sol_short_flag(ssf), .frame_ok(fok), .frame_err(ferr), .params_stale(stale)
    );

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] nx(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : nx

    // On cycles in one period window
    function automatic logic [19:0] exp_on(input int e, p, o);
        return 20'((e == 0) ? 0 : ((o >= p) ? p : o) * TC);
    endfunction : exp_on

    task automatic cmp(input logic [19:0] g, e);
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %0t %0h %0h", $time, g, e);
        end
    endtask : cmp

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    task automatic bound(input int c, lim);
        if (c >= lim)
        begin
            mismatches++;
            finish_test;
        end
    endtask : bound

    task automatic tx;
        u_host.send(f, 244);
        for (n = 0; fok !== 1'b1 && n < 30; n++) @(negedge clk);
        bound(n, 30);
        cmp(20'({stale, fok}), 20'h00001);
    endtask : tx

    task automatic sol(input int i, e, p, o);
        f[idc_pkg::SOL_FIELD * i + idc_pkg::SOL_EN_POS] = e[0];
        f[idc_pkg::SOL_FIELD * i + idc_pkg::SOL_PER_POS +: 20] = p[19:0];
        f[idc_pkg::SOL_FIELD * i + idc_pkg::SOL_ON_POS +: 20] = o[19:0];
        ena[i] = e;
        per[i] = p;
        ont[i] = o;
    endtask : sol

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {reset, ce, sup, cmd, pk, hd, rf, oc, so, ss} = 31'h60000000;
        {mismatches, checks, f, lf} = '0;
        repeat (3) @(negedge clk);
        cmp({idr, ips, iof, isf, sdr}, 20'h00000);
        reset = 1'b0;
        lf = nx(8'h4C);
        sol(0, 1, 4 + lf[2:0], lf[6:4]);
        sol(1, 1, 5, 0);
        sol(2, 1, 3, 3);
        sol(3, 0, 4, 2);
        f[idc_pkg::INJ_BASE +: 16] = 16'h0002;
        // Channel 2 stands for a high-resistance injector
        f[idc_pkg::INJ_BASE + 32 +: 16] = 16'h0000;
        so = 4'hB;
        tx;
        repeat (600) @(negedge clk);
        for (int i = 0; i < 4; i++)
        begin
            n = 0;
            repeat (per[i] * TC)
            begin
                @(negedge clk);
                n += int'(sdr[i]);
            end
            cmp(20'(n), exp_on(ena[i], per[i], ont[i]));
        end
        so = 4'h0;
        repeat (10) @(negedge clk);
        cmp(20'(sof), 20'h0000B);
        {pk, hd, sup, cmd} = 13'h1631;
        for (n = 0; idr[0] !== 1'b1 && n < 20; n++) @(negedge clk);
        bound(n, 20);
        for (n = 0; ips[0] === 1'b1 && n < 300; n++) @(negedge clk);
        cmp(20'(n >= TC - 1 && n <= 2 * TC + 2), 20'h00001);
        cmp(20'(idr[0]), 20'h00001);
        cmd = 4'h5;
        repeat (20) @(negedge clk);
        cmd = 4'h0;
        repeat (20) @(negedge clk);
        cmp(20'(iof), 20'h00004);
        {sup, cmd} = 5'h02;
        repeat (20) @(negedge clk);
        cmp(20'(idr), 20'h00000);
        {rf, sup, ss} = 9'h054;
        repeat (20) @(negedge clk);
        cmp(20'({isf, idr, ssf, sdr & 4'hE}), 20'h02040);
        f[idc_pkg::CLR_BASE + idc_pkg::CLR_INJ_SHORT + 1] = 1'b1;
        f[idc_pkg::CLR_BASE + idc_pkg::CLR_SOL_SHORT + 2] = 1'b1;
        f[idc_pkg::CLR_BASE + idc_pkg::CLR_SOL_OPEN +: 4] = 4'hF;
        {rf, ss} = 8'h00;
        tx;
        repeat (5) @(negedge clk);
        cmp(20'({isf, ssf, sof}), 20'h00240);
        cmd = 4'h0;
        sol(2, 0, 3, 3);
        tx;
        // Clears go out on these two frames only, never on every frame
        f[idc_pkg::CLR_BASE +: 16] = 16'h0000;
        tx;
        cmp(20'({isf, ssf}), 20'h00000);
        cmd = 4'h8;
        repeat (10100) @(negedge clk);
        oc = 4'h8;
        repeat (10) @(negedge clk);
        cmp(20'({isf, idr}), 20'h00080);
        // Cut frame: refused, and no refresh of the watchdog
        u_host.send(f, 8);
        for (n = 0; ferr !== 1'b1 && n < 30; n++) @(negedge clk);
        bound(n, 30);
        cmp(20'({stale, fok, ferr}), 20'h00005);
        finish_test;
    end
endmodule : testbench

`default_nettype wire
